/* File: rtl/ppb_pin_override.sv */
// module: pwm pin override, write lock and leading-edge blanking
// How it works
// - override drives pins from forced level bits
// - lock bit blocks io writes until unlocked
// - twelve-bit blanking delay gates fault and limit
// - blanking bits 15-12 read zero, ignore writes
module ppb_pin_override #(
	parameter int BLANK_BITS = 12
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_config_write_lock,
	input wire logic gen_high,
	input wire logic gen_low,
	input wire logic fault_in,
	input wire logic climit_in,
	input wire logic fault_response_mode,
	input wire logic current_limit_response_mode,
	input wire logic pwm_edge,
	output logic high_side_output,
	output logic low_side_output,
	output logic [1:0] pin_pair_mode,
	output logic fault_active,
	output logic climit_active
);
	timeunit 1ns;
	timeprecision 1ps;
	// ================================================================
	// helper functions
	// address decode: one bit per register, zero for unmapped
	function automatic logic [3:0] reg_hit(input logic [7:0] a);
		logic [3:0] hit_bits;
		hit_bits = 4'h0;
		case (a)
		ppb_pkg::ADDR_IO_CONTROL: begin
			hit_bits = 4'h1;
		end
		ppb_pkg::ADDR_BLANKING: begin
			hit_bits = 4'h2;
		end
		ppb_pkg::ADDR_UNLOCK: begin
			hit_bits = 4'h4;
		end
		ppb_pkg::ADDR_STATUS: begin
			hit_bits = 4'h8;
		end
		default: begin
			hit_bits = 4'h0;
		end
		endcase
		return hit_bits;
	endfunction
	// read mux, unmapped offsets read as zero
	function automatic logic [31:0] read_word(
		input logic [3:0] sel,
		input logic [15:0] ctl,
		input logic [15:0] blk,
		input logic [4:0] stat
	);
		logic [31:0] word;
		word = ppb_pkg::UNMAPPED_READ;
		case (sel)
		4'h1: begin
			word = {16'h0000, ctl};
		end
		4'h2: begin
			word = {16'h0000, blk & ppb_pkg::BLANK_MASK};
		end
		// unlock keys are write-only, so they never read back
		4'h4: begin
			word = ppb_pkg::UNMAPPED_READ;
		end
		4'h8: begin
			word = {27'h000_0000, stat};
		end
		default: begin
			word = ppb_pkg::UNMAPPED_READ;
		end
		endcase
		return word;
	endfunction
	// unlock sequencer: a wrong key falls back to idle
	function automatic ppb_pkg::ppb_lock_e unlock_step(
		input ppb_pkg::ppb_lock_e cur,
		input logic [15:0] key
	);
		ppb_pkg::ppb_lock_e nxt;
		nxt = ppb_pkg::ppb_lk_idle;
		case (cur)
		ppb_pkg::ppb_lk_idle: begin
			if (key == ppb_pkg::UNLOCK_KEY1) begin
				nxt = ppb_pkg::ppb_lk_key1;
			end
		end
		ppb_pkg::ppb_lk_key1: begin
			if (key == ppb_pkg::UNLOCK_KEY2) begin
				nxt = ppb_pkg::ppb_lk_open;
			end
		end
		default: begin
			nxt = ppb_pkg::ppb_lk_idle;
		end
		endcase
		return nxt;
	endfunction
	// override bit chooses the forced level over the generator
	function automatic logic pick_level(
		input logic force_en,
		input logic forced,
		input logic gen
	);
		logic lvl;
		lvl = gen;
		if (force_en) begin
			lvl = forced;
		end
		return lvl;
	endfunction
	// a trip input counts only once blanking has run out
	function automatic logic qualify(
		input logic pin,
		input logic enable,
		input logic [BLANK_BITS-1:0] count
	);
		return pin && enable && count == '0;
	endfunction
	// ================================================================
	// input synchronisers
	// only the second stage is read; the first may be metastable
	logic [1:0] flt_sync;
	logic [1:0] cl_sync;
	logic [1:0] next_flt_sync;
	logic [1:0] next_cl_sync;
	always_comb begin
		next_flt_sync = {flt_sync[0], fault_in};
		next_cl_sync = {cl_sync[0], climit_in};
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			flt_sync <= 2'h0;
			cl_sync <= 2'h0;
		end else begin
			flt_sync <= next_flt_sync;
			cl_sync <= next_cl_sync;
		end
	end
	// ================================================================
	// apb registers and unlock sequence
	logic [15:0] io_ctl;
	logic [15:0] blank;
	ppb_pkg::ppb_lock_e lk;
	logic [31:0] rd;
	logic rdy;
	logic err;
	logic [15:0] next_io_ctl;
	logic [15:0] next_blank;
	ppb_pkg::ppb_lock_e next_lk;
	logic [31:0] next_rd;
	logic next_rdy;
	logic next_err;
	logic setup;
	logic commit;
	logic [3:0] hit;
	logic io_open;
	logic [4:0] status_word;
	logic wr_refused;
	logic next_wr_refused;
	always_comb begin
		setup = psel && !penable && !rdy;
		// writes land on the edge that samples pready
		commit = psel && penable && rdy && pwrite;
		hit = reg_hit(paddr);
		io_open = !pin_config_write_lock || lk == ppb_pkg::ppb_lk_open;
		status_word = {wr_refused, climit_active, fault_active,
			lk == ppb_pkg::ppb_lk_open, pin_config_write_lock};
		next_io_ctl = io_ctl;
		next_blank = blank;
		next_lk = lk;
		next_wr_refused = wr_refused;
		next_rd = ppb_pkg::UNMAPPED_READ;
		next_rdy = setup;
		next_err = setup && hit == 4'h0;
		if (setup) begin
			next_rd = read_word(hit, io_ctl, blank, status_word);
		end
		if (commit && hit[0]) begin
			// any io write attempt closes the lock again
			if (io_open) begin
				next_io_ctl = pwdata[15:0];
				next_wr_refused = 1'b0;
			end else begin
				// refused data is dropped; the bus still answers okay
				next_wr_refused = 1'b1;
			end
			next_lk = ppb_pkg::ppb_lk_idle;
		end
		if (commit && hit[1]) begin
			// bits 15-12 are never stored, so they read back zero
			next_blank = pwdata[15:0] & ppb_pkg::BLANK_MASK;
		end
		if (commit && hit[2]) begin
			next_lk = unlock_step(lk, pwdata[15:0]);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			io_ctl <= ppb_pkg::RST_IO_CONTROL;
			blank <= ppb_pkg::RST_BLANKING;
			lk <= ppb_pkg::ppb_lk_idle;
			rd <= 32'h0000_0000;
			rdy <= 1'b0;
			err <= 1'b0;
			wr_refused <= 1'b0;
		end else begin
			io_ctl <= next_io_ctl;
			blank <= next_blank;
			lk <= next_lk;
			rd <= next_rd;
			rdy <= next_rdy;
			err <= next_err;
			wr_refused <= next_wr_refused;
		end
	end
	assign prdata = rd;
	assign pready = rdy;
	assign pslverr = err;
	// ================================================================
	// leading-edge blanking: inputs ignored for delay cycles after edge
	logic [BLANK_BITS-1:0] bcnt;
	logic [BLANK_BITS-1:0] next_bcnt;
	// edge_d resets low, the idle level of the edge marker
	logic edge_d;
	logic next_edge_d;
	always_comb begin
		next_edge_d = pwm_edge;
		next_bcnt = bcnt;
		// a new edge reloads the count, even in mid-blank
		if (pwm_edge && !edge_d) begin
			next_bcnt = blank[BLANK_BITS-1:0];
		end else if (bcnt != '0) begin
			next_bcnt = bcnt - 1'b1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bcnt <= '0;
			edge_d <= 1'b0;
		end else begin
			bcnt <= next_bcnt;
			edge_d <= next_edge_d;
		end
	end
	// ================================================================
	// pin drive priority: fault, then current limit, then override
	logic hi_q;
	logic lo_q;
	logic flt_q;
	logic cl_q;
	logic [1:0] mode_q;
	logic next_hi;
	logic next_lo;
	logic next_flt;
	logic next_cl;
	always_comb begin
		// blanking covers both the fault and current-limit paths
		next_flt = qualify(flt_sync[1], fault_response_mode, bcnt);
		next_cl = qualify(cl_sync[1], current_limit_response_mode,
			bcnt);
		next_hi = pick_level(io_ctl[ppb_pkg::POS_HIGH_FORCE_EN],
			io_ctl[ppb_pkg::POS_FORCED_HI], gen_high);
		next_lo = pick_level(io_ctl[ppb_pkg::POS_LOW_FORCE_EN],
			io_ctl[ppb_pkg::POS_FORCED_LO], gen_low);
		if (next_flt) begin
			next_hi = io_ctl[ppb_pkg::POS_FAULT_HI];
			next_lo = io_ctl[ppb_pkg::POS_FAULT_LO];
		end else if (next_cl) begin
			next_hi = io_ctl[ppb_pkg::POS_CLIM_HI];
			next_lo = io_ctl[ppb_pkg::POS_CLIM_LO];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			flt_q <= 1'b0;
			cl_q <= 1'b0;
			mode_q <= 2'h0;
		end else begin
			hi_q <= next_hi;
			lo_q <= next_lo;
			flt_q <= next_flt;
			cl_q <= next_cl;
			mode_q <= io_ctl[ppb_pkg::POS_MODE_LSB +: 2];
		end
	end
	assign high_side_output = hi_q;
	assign low_side_output = lo_q;
	assign fault_active = flt_q;
	assign climit_active = cl_q;
	assign pin_pair_mode = mode_q;
endmodule

/* File: inc/ppb_pkg.sv */
// package: register map, field positions and reset values for pin override
package ppb_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// ================================================================
	// register byte addresses
	localparam logic [7:0] ADDR_IO_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_BLANKING = 8'h04;
	localparam logic [7:0] ADDR_UNLOCK = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	// ================================================================
	// pin i/o control fields
	localparam int POS_HIGH_FORCE_EN = 9;
	localparam int POS_LOW_FORCE_EN = 8;
	localparam int POS_FORCED_HI = 7;
	localparam int POS_FORCED_LO = 6;
	localparam int POS_FAULT_HI = 5;
	localparam int POS_FAULT_LO = 4;
	localparam int POS_CLIM_HI = 3;
	localparam int POS_CLIM_LO = 2;
	localparam int POS_MODE_LSB = 10;
	// ================================================================
	// blanking field
	localparam int BLANK_W = 12;
	localparam logic [15:0] BLANK_MASK = 16'h0FFF;
	// ================================================================
	// reset values and unlock keys
	localparam logic [15:0] RST_IO_CONTROL = 16'h0000;
	localparam logic [15:0] RST_BLANKING = 16'h0000;
	localparam logic [15:0] UNLOCK_KEY1 = 16'hABCD;
	localparam logic [15:0] UNLOCK_KEY2 = 16'h4321;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// ================================================================
	// unlock sequencer states
	typedef enum logic [2:0] {
		ppb_lk_idle = 3'b001,
		ppb_lk_key1 = 3'b010,
		ppb_lk_open = 3'b100
	} ppb_lock_e;
endpackage

/* File: test/ppb_monitor.sv */
// checker: apb answer timing and fault/limit qualification
module ppb_monitor (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fault_in,
	input wire logic climit_in,
	input wire logic fault_active,
	input wire logic climit_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// ================================================================
	// properties
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no answer");
	property p_err;
		pslverr |-> pready && paddr != ppb_pkg::ADDR_IO_CONTROL
			&& paddr != ppb_pkg::ADDR_BLANKING
			&& paddr != ppb_pkg::ADDR_UNLOCK
			&& paddr != ppb_pkg::ADDR_STATUS;
	endproperty
	a_err: assert property (p_err) else $error("bad error");
	property p_blank;
		pready && paddr == 8'h04 |-> prdata[31:12] == 0;
	endproperty
	a_blank: assert property (p_blank) else $error("high bits");
	// 2 sync stages plus output register
	property p_fault; $rose(fault_active) |-> $past(fault_in, 3); endproperty
	a_fault: assert property (p_fault) else $error("fault early");
	property p_clim; climit_active |-> $past(climit_in, 3); endproperty
	a_clim: assert property (p_clim) else $error("limit early");
	c_fault: cover property ($rose(fault_active));
	c_clim: cover property ($rose(climit_active));
	c_err: cover property (pslverr);
	c_wr: cover property (pready && pwrite);
endmodule
bind ppb_pin_override ppb_monitor ppb_monitor_i (.*);

/* File: test/ppb_power_stage.sv */
// model: power stage reporting a commanded trip or shoot-through
module ppb_power_stage (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic trip,
	input wire logic high_side_output,
	input wire logic low_side_output,
	output logic fault_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// both switches on would short the rail
	always_ff @(posedge clk_sys)
		fault_in <= !srst && (trip || (high_side_output && low_side_output));
endmodule

/* File: test/ppb_pin_override_test.sv */
// bench: registers, override, fault response and write lock
module ppb_pin_override_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, high_side_output, low_side_output, fault_in;
	logic pin_config_write_lock = 0, gen_high = 0, gen_low = 0, trip = 0;
	logic climit_in = 0, fault_response_mode = 0, pwm_edge = 0;
	logic current_limit_response_mode = 0, fault_active, climit_active;
	logic [1:0] pin_pair_mode;
	logic [4:0] pins;
	assign pins = {climit_active, high_side_output, low_side_output,
		pin_pair_mode};
	int mismatches = 0, checks_done = 0;
	ppb_pin_override ppb_pin_override_i (.*);
	ppb_power_stage ppb_power_stage_i (.*);
	initial forever #2 clk_sys = ~clk_sys;
	// ================================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		// only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic settle_chk(input logic [31:0] exp);
		repeat (6) @(posedge clk_sys);
		chk({fault_active, high_side_output, low_side_output}, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ================================================================
	// scenarios
	task automatic t_regs;
		bus(0, ppb_pkg::ADDR_BLANKING, 0);
		chk(rd, 0);
		bus(1, ppb_pkg::ADDR_BLANKING, 32'hFFFF_FFFF);
		bus(0, ppb_pkg::ADDR_BLANKING, 0);
		chk(rd, 32'h0000_0FFF);
		bus(0, 8'h40, 0);
		chk(err, 1);
		bus(1, ppb_pkg::ADDR_BLANKING, 0);
		$display("regs done");
	endtask
	task automatic t_force;
		bus(1, ppb_pkg::ADDR_IO_CONTROL, 32'h0000_0380);
		settle_chk(3'b010);
		bus(1, ppb_pkg::ADDR_IO_CONTROL, 32'h0000_0340);
		settle_chk(3'b001);
		$display("force done");
	endtask
	task automatic t_fault;
		bus(1, ppb_pkg::ADDR_IO_CONTROL, 32'h0000_0390);
		fault_response_mode <= 1;
		trip <= 1;
		settle_chk(3'b101);
		trip <= 0;
		settle_chk(3'b010);
		$display("fault done");
	endtask
	task automatic t_limit;
		bus(1, ppb_pkg::ADDR_IO_CONTROL, 32'h0000_0808);
		gen_low <= 1;
		repeat (6) @(posedge clk_sys);
		chk(pins, 32'h0000_0006);
		current_limit_response_mode <= 1;
		climit_in <= 1;
		repeat (6) @(posedge clk_sys);
		chk(pins, 32'h0000_001A);
		climit_in <= 0;
		bus(1, ppb_pkg::ADDR_BLANKING, 32'h0000_0014);
		// twenty-cycle blank: look at cycle 12 and again at 27
		pwm_edge <= 1;
		climit_in <= 1;
		repeat (12) @(posedge clk_sys);
		chk(pins, 32'h0000_0006);
		repeat (15) @(posedge clk_sys);
		chk(pins, 32'h0000_001A);
		pwm_edge <= 0;
		climit_in <= 0;
		current_limit_response_mode <= 0;
		bus(1, ppb_pkg::ADDR_BLANKING, 0);
		repeat (6) @(posedge clk_sys);
		chk(pins, 32'h0000_0006);
		$display("limit done");
	endtask
	task automatic t_lock;
		pin_config_write_lock <= 1;
		bus(1, ppb_pkg::ADDR_IO_CONTROL, 32'h0000_0040);
		bus(0, ppb_pkg::ADDR_IO_CONTROL, 0);
		chk(rd, 32'h0000_0808);
		chk(err, 0);
		bus(0, ppb_pkg::ADDR_STATUS, 0);
		chk(rd, 32'h0000_0011);
		bus(1, ppb_pkg::ADDR_UNLOCK, 32'h0000_ABCD);
		bus(1, ppb_pkg::ADDR_UNLOCK, 32'h0000_4321);
		bus(0, ppb_pkg::ADDR_STATUS, 0);
		chk(rd, 32'h0000_0013);
		bus(1, ppb_pkg::ADDR_IO_CONTROL, 32'h0000_0040);
		bus(0, ppb_pkg::ADDR_IO_CONTROL, 0);
		chk(rd, 32'h0000_0040);
		bus(0, ppb_pkg::ADDR_STATUS, 0);
		chk(rd, 32'h0000_0001);
		$display("lock done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		srst <= 0;
		t_regs;
		t_force;
		t_fault;
		t_limit;
		t_lock;
		tally_and_finish;
	end
	// all scenarios need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		tally_and_finish;
	end
endmodule
